// File: core/tar_thermal_alert.sv
// What this block does
// - Power-up or either reset pin zeroes fan level, ramp counter and ramp register.
// - With ramping off, a written fan level appears on the output at once.
// - Enabling ramping preloads the counter with the fan level, output holds.
// - Counter steps toward target at selected rate, stops there, reverses on new target.
// - Overtemperature outputs act regardless of any ramp in progress.
// - Remote limit status bit 0 and its alert set only after three consecutive out-of-limit conversions.
// - Unmasked, alert goes low on remote limit violation or while overtemperature low.
// - Cleared alert stays off until three in-limit, then three out-of-limit conversions.
// - Mask bit blocks the alert source while the status bit still sets.
// - Writing one clears a status bit, except the live general input and overtemperature bits.
// - Writing one to status bits 1 and 2 toggles them: sets a software interrupt when clear, clears it when set.
// - Configuration bit 1 enables alert; clearing it releases alert, status kept.
// - Each measurement compared to limits; unmasked status bits ORed onto alert.
// - Both overtemperature outputs behave identically and assert together.
// - Overtemperature follows only the hardware trip limits, not alert limits.
// - Overtemperature asserts after three over, releases after three five degrees below.
// - While overtemperature, fan output forced full scale and fan-off negated.
// - After forcing ends, fan output returns to the ramp counter when ramping, else to the latest programmed value.
// - Status bit 4 follows general input live, inverted by configuration bit 6.
// - Auxiliary reset restores all and halts conversions; system reset clears lock, fan.
// - Configuration bit 4 soft reset restores status, mask and config except lock; rearms alert only.
// - Power-on reset initialises configuration, status, mask, fan and trip registers.
// - Lock bit settable only to one; selects and write-locks programmable trips.
// - Default trips are 100 degrees remote and 70 degrees internal.
`timescale 1ns/1ps
`default_nettype none
`include "tar_defs.svh"

module tar_thermal_alert
   import tar_pkg::*;
#(
   parameter int        RAMP_BASE_CYC = `TAR_RAMP_BASE_CYC,
   parameter tar_byte_t COMPANY_ID    = 8'h5a, // Arbitrary value
   parameter tar_byte_t REVISION_ID   = 8'h20  // Arbitrary value
) (
   input  wire logic       clk_sys_in,
   input  wire logic       srst_in,
   input  wire logic       auxiliary_reset_n_in,
   input  wire logic       system_reset_n_in,
   input  wire logic       general_input_in,
   input  wire logic       conv_valid_in,
   input  wire logic [7:0] remote_temp_in,
   input  wire logic [7:0] internal_temp_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   output var  logic [7:0] reg_rdata_out,
   output var  logic [7:0] fan_level_out,
   output var  logic       fan_off_out,
   output var  logic       alert_n_out,
   output var  logic       alert_oe_out,
   output var  logic       overtemp_out_a_n_out,
   output var  logic       overtemp_out_a_oe_out,
   output var  logic       overtemp_out_b_n_out,
   output var  logic       overtemp_out_b_oe_out
);

   // ****************************************
   // Resets and decode
   // ****************************************
   wire logic full_rst;
   wire logic sys_rst;
   wire logic conv_ok;
   wire logic wr_cfg;
   wire logic wr_stat;
   wire logic wr_mask;
   wire logic wr_fan;
   wire logic wr_ramp;
   wire logic wr_int_trip;
   wire logic wr_rem_trip;
   wire logic wr_high;
   wire logic wr_low;
   wire logic soft_rst;
   tar_byte_t cfg;
   tar_byte_t mask;
   tar_byte_t int_trip;
   tar_byte_t rem_trip;
   tar_byte_t rem_high;
   tar_byte_t rem_low;
   tar_byte_t next_cfg;

   assign full_rst = srst_in | ~auxiliary_reset_n_in;
   assign sys_rst  = ~system_reset_n_in;
   assign conv_ok  = conv_valid_in & auxiliary_reset_n_in;

   assign wr_cfg      = reg_wr_in && (reg_addr_in == `TAR_ADDR_CONFIG);
   assign wr_stat     = reg_wr_in && (reg_addr_in == `TAR_ADDR_STATUS);
   assign wr_mask     = reg_wr_in && (reg_addr_in == `TAR_ADDR_MASK);
   assign wr_fan      = reg_wr_in && (reg_addr_in == `TAR_ADDR_FAN_LEVEL);
   assign wr_ramp     = reg_wr_in && (reg_addr_in == `TAR_ADDR_RAMP);
   assign wr_high     = reg_wr_in && (reg_addr_in == `TAR_ADDR_REM_HIGH);
   assign wr_low      = reg_wr_in && (reg_addr_in == `TAR_ADDR_REM_LOW);
   assign wr_int_trip = reg_wr_in && (reg_addr_in == `TAR_ADDR_INT_TRIP_PROG) &&
                        !cfg[`TAR_CFG_LOCK];
   assign wr_rem_trip = reg_wr_in && (reg_addr_in == `TAR_ADDR_REM_TRIP_PROG) &&
                        !cfg[`TAR_CFG_LOCK];
   assign soft_rst    = wr_cfg && reg_wdata_in[`TAR_CFG_SOFT_RST];

   // ****************************************
   // Configuration, mask and limits
   // ****************************************

   // lock only sets; soft reset keeps it
   assign next_cfg = soft_rst ?
                     (`TAR_CONFIG_RST | (cfg & (8'h01 << `TAR_CFG_LOCK))) :
                     ((reg_wdata_in & ~(8'h01 << `TAR_CFG_SOFT_RST)) |
                      (cfg & (8'h01 << `TAR_CFG_LOCK)));

   always_ff @(posedge clk_sys_in) begin
      if (full_rst) begin
         cfg      <= `TAR_CONFIG_RST;
         mask     <= 8'h00;
         int_trip <= `TAR_INT_TRIP_PROG_RST;
         rem_trip <= `TAR_REM_TRIP_RST;
         rem_high <= `TAR_REM_HIGH_RST;
         rem_low  <= `TAR_REM_LOW_RST;
      end else begin
         if (sys_rst) begin
            cfg[`TAR_CFG_LOCK] <= 1'b0;
         end else if (wr_cfg) begin
            cfg <= next_cfg;
         end
         if (soft_rst) begin
            mask <= 8'h00;
         end else if (wr_mask) begin
            mask <= reg_wdata_in;
         end
         if (wr_int_trip) begin
            int_trip <= reg_wdata_in;
         end
         if (wr_rem_trip) begin
            rem_trip <= reg_wdata_in;
         end
         if (wr_high) begin
            rem_high <= reg_wdata_in;
         end
         if (wr_low) begin
            rem_low <= reg_wdata_in;
         end
      end
   end

   // ****************************************
   // Overtemperature per sensor
   // ****************************************
   tar_byte_t  temp_s [2];
   tar_byte_t  trip_s [2];
   tar_therm_t therm_st [2];
   wire logic  therm_any;

   assign temp_s[0] = remote_temp_in;
   assign temp_s[1] = internal_temp_in;
   assign trip_s[0] = cfg[`TAR_CFG_LOCK] ? rem_trip : `TAR_REM_TRIP_RST;
   assign trip_s[1] = cfg[`TAR_CFG_LOCK] ? int_trip : `TAR_INT_TRIP_DEF_VAL;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_therm
         logic [1:0] over_cnt;
         logic [1:0] under_cnt;
         wire logic  over;
         wire logic  under;
         assign over  = $signed(temp_s[gi]) > $signed(trip_s[gi]);
         assign under = $signed({temp_s[gi][7], temp_s[gi]}) <=
                        ($signed({trip_s[gi][7], trip_s[gi]}) - $signed(9'(`TAR_HYST_DEG)));
         always_ff @(posedge clk_sys_in) begin
            if (full_rst) begin
               over_cnt     <= 2'h0;
               under_cnt    <= 2'h0;
               therm_st[gi] <= TAR_NORMAL;
            end else if (conv_ok) begin
               over_cnt  <= over ? ((over_cnt == 2'h3) ? 2'h3 : over_cnt + 2'h1) : 2'h0;
               under_cnt <= under ? ((under_cnt == 2'h3) ? 2'h3 : under_cnt + 2'h1) : 2'h0;
               case (therm_st[gi])
                  TAR_NORMAL: begin
                     if (over && over_cnt >= 2'h2) begin
                        therm_st[gi] <= TAR_FORCED;
                     end
                  end
                  TAR_FORCED: begin
                     if (under && under_cnt >= 2'h2) begin
                        therm_st[gi] <= TAR_NORMAL;
                     end
                  end
                  default: begin
                     therm_st[gi] <= TAR_NORMAL;
                  end
               endcase
            end
         end
      end
   endgenerate

   assign therm_any = (therm_st[0] == TAR_FORCED) || (therm_st[1] == TAR_FORCED);

   // ****************************************
   // Remote limit alert source
   // ****************************************
   logic [1:0] ool_cnt;
   logic [1:0] inl_cnt;
   logic       armed;
   logic [2:0] stat_lat;
   wire logic  ool;
   wire logic  ool_set;
   wire logic  inl_rearm;
   wire logic  in_level;
   wire logic [7:0] stat_view;
   wire logic [2:0] stat_clr;
   wire logic [2:0] stat_set;

   assign ool       = ($signed(remote_temp_in) > $signed(rem_high)) ||
                      ($signed(remote_temp_in) < $signed(rem_low));
   assign ool_set   = conv_ok && ool && armed && (ool_cnt >= 2'h2);
   assign inl_rearm = conv_ok && !ool && (inl_cnt >= 2'h2);
   assign in_level  = general_input_in ^ cfg[`TAR_CFG_INPUT_INV];
   assign stat_view = {2'b00, therm_any, in_level, 1'b0, stat_lat};
   assign stat_clr  = wr_stat ? {reg_wdata_in[2:1] & stat_lat[2:1],
                                 reg_wdata_in[0]} : 3'h0;
   assign stat_set  = {wr_stat && reg_wdata_in[`TAR_ST_SW2] && !stat_lat[2],
                       wr_stat && reg_wdata_in[`TAR_ST_SW1] && !stat_lat[1],
                       ool_set};

   always_ff @(posedge clk_sys_in) begin
      if (full_rst || soft_rst) begin
         ool_cnt  <= 2'h0;
         inl_cnt  <= 2'h0;
         armed    <= 1'b1;
         stat_lat <= 3'h0;
      end else begin
         if (conv_ok) begin
            ool_cnt <= ool ? ((ool_cnt == 2'h3) ? 2'h3 : ool_cnt + 2'h1) : 2'h0;
            inl_cnt <= !ool ? ((inl_cnt == 2'h3) ? 2'h3 : inl_cnt + 2'h1) : 2'h0;
         end
         if (ool_set) begin
            armed <= 1'b0;
         end else if (inl_rearm) begin
            armed <= 1'b1;
         end
         // Set wins over clear
         stat_lat[2:1] <= (stat_lat[2:1] & ~stat_clr[2:1]) | stat_set[2:1];
         stat_lat[0]   <= (stat_lat[0] & ~stat_clr[0] & ~inl_rearm) | stat_set[0];
      end
   end

   // ****************************************
   // Fan level and ramp
   // ****************************************
   tar_byte_t   fan_level;
   tar_byte_t   ramp_cnt;
   tar_byte_t   ramp_ctl;
   logic [31:0] base_cnt;
   tar_byte_t   step_cnt;
   wire logic   base_tick;
   wire logic   step_tick;
   wire logic   ramp_on;
   wire logic [7:0] step_len;
   wire logic [7:0] fan_src;

   assign ramp_on   = ramp_ctl[`TAR_RAMP_EN];
   assign base_tick = (base_cnt == 32'(RAMP_BASE_CYC - 1));
   assign step_len  = 8'h01 << ramp_ctl[3:1];
   assign step_tick = base_tick && (step_cnt >= step_len - 8'h01);

   always_ff @(posedge clk_sys_in) begin
      if (full_rst || sys_rst) begin
         fan_level <= 8'h00;
         ramp_cnt  <= 8'h00;
         ramp_ctl  <= 8'h00;
         base_cnt  <= 32'h0;
         step_cnt  <= 8'h00;
      end else begin
         base_cnt <= base_tick ? 32'h0 : base_cnt + 32'h1;
         if (base_tick) begin
            step_cnt <= step_tick ? 8'h00 : step_cnt + 8'h01;
         end
         if (wr_fan) begin
            fan_level <= reg_wdata_in;
         end
         if (wr_ramp) begin
            ramp_ctl <= reg_wdata_in;
         end
         if (!ramp_on) begin
            ramp_cnt <= fan_level;
         end else if (step_tick && ramp_cnt < fan_level) begin
            ramp_cnt <= ramp_cnt + 8'h01;
         end else if (step_tick && ramp_cnt > fan_level) begin
            ramp_cnt <= ramp_cnt - 8'h01;
         end
      end
   end

   assign fan_src = ramp_on ? ramp_cnt : fan_level;

   // ****************************************
   // Outputs
   // ****************************************
   wire logic alert_act;
   wire logic [7:0] rd_mux;

   assign alert_act = cfg[`TAR_CFG_INT_EN] && (|(stat_view & ~mask));

   assign rd_mux = (reg_addr_in == `TAR_ADDR_CONFIG)        ? cfg :
                   (reg_addr_in == `TAR_ADDR_STATUS)        ? stat_view :
                   (reg_addr_in == `TAR_ADDR_MASK)          ? mask :
                   (reg_addr_in == `TAR_ADDR_FAN_LEVEL)     ? fan_level :
                   (reg_addr_in == `TAR_ADDR_RAMP)          ? ramp_ctl :
                   (reg_addr_in == `TAR_ADDR_INT_TRIP_PROG) ? int_trip :
                   (reg_addr_in == `TAR_ADDR_REM_TRIP_PROG) ? rem_trip :
                   (reg_addr_in == `TAR_ADDR_INT_TRIP_DEF)  ? `TAR_INT_TRIP_DEF_VAL :
                   (reg_addr_in == `TAR_ADDR_REM_TRIP_DEF)  ? `TAR_REM_TRIP_RST :
                   (reg_addr_in == `TAR_ADDR_REM_HIGH)      ? rem_high :
                   (reg_addr_in == `TAR_ADDR_REM_LOW)       ? rem_low :
                   (reg_addr_in == `TAR_ADDR_COMPANY)       ? COMPANY_ID :
                   (reg_addr_in == `TAR_ADDR_REVISION)      ? REVISION_ID : 8'h00;

   always_ff @(posedge clk_sys_in) begin
      if (full_rst) begin
         reg_rdata_out         <= 8'h00;
         fan_level_out         <= 8'h00;
         fan_off_out           <= 1'b1;
         alert_n_out           <= 1'b1;
         alert_oe_out          <= 1'b0;
         overtemp_out_a_n_out  <= 1'b1;
         overtemp_out_a_oe_out <= 1'b0;
         overtemp_out_b_n_out  <= 1'b1;
         overtemp_out_b_oe_out <= 1'b0;
      end else begin
         if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
         end
         fan_level_out <= therm_any ? `TAR_FULL_SCALE : (sys_rst ? 8'h00 : fan_src);
         fan_off_out   <= !therm_any && (sys_rst || (fan_src == 8'h00));
         alert_n_out   <= !alert_act;
         alert_oe_out  <= alert_act;
         overtemp_out_a_n_out  <= !therm_any;
         overtemp_out_a_oe_out <= therm_any;
         overtemp_out_b_n_out  <= !therm_any;
         overtemp_out_b_oe_out <= therm_any;
      end
   end

endmodule
`default_nettype wire

// File: core/tar_defs.svh
`ifndef TAR_DEFS_SVH
`define TAR_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define TAR_ADDR_INT_TRIP_PROG   8'h13
`define TAR_ADDR_REM_TRIP_PROG   8'h14
`define TAR_ADDR_INT_TRIP_DEF    8'h17
`define TAR_ADDR_REM_TRIP_DEF    8'h18
`define TAR_ADDR_REM_HIGH        8'h30
`define TAR_ADDR_REM_LOW         8'h31
`define TAR_ADDR_COMPANY         8'h3e
`define TAR_ADDR_REVISION        8'h3f
`define TAR_ADDR_CONFIG          8'h40
`define TAR_ADDR_STATUS          8'h41
`define TAR_ADDR_FAN_LEVEL       8'h42
`define TAR_ADDR_MASK            8'h43
`define TAR_ADDR_RAMP            8'hc0

// ****************************************
// Reset values
// ****************************************
`define TAR_CONFIG_RST           8'h21
`define TAR_INT_TRIP_PROG_RST    8'h7f
`define TAR_REM_TRIP_RST         8'h64
`define TAR_INT_TRIP_DEF_VAL     8'h46
`define TAR_REM_HIGH_RST         8'h7f
`define TAR_REM_LOW_RST          8'h80
`define TAR_FULL_SCALE           8'hff

// ****************************************
// Field positions
// ****************************************
`define TAR_CFG_INT_EN           1
`define TAR_CFG_LOCK             3
`define TAR_CFG_SOFT_RST         4
`define TAR_CFG_INPUT_INV        6
`define TAR_ST_REM_OOL           0
`define TAR_ST_SW1               1
`define TAR_ST_SW2               2
`define TAR_ST_INPUT             4
`define TAR_ST_THERM             5
`define TAR_RAMP_EN              0

// ****************************************
// Timing
// ****************************************
`define TAR_CLK_PERIOD_NS        40
`define TAR_RAMP_BASE_NS         1000000
`define TAR_RAMP_BASE_CYC        (`TAR_RAMP_BASE_NS / `TAR_CLK_PERIOD_NS)
`define TAR_HYST_DEG             5
`define TAR_CONSEC               3

`endif

// File: core/tar_pkg.sv
package tar_pkg;

   typedef logic [7:0] tar_byte_t;

   typedef enum logic [0:0] {
      TAR_NORMAL = 1'b0,
      TAR_FORCED = 1'b1
   } tar_therm_t;

endpackage

// File: tb/tar_thermal_alert_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tar_thermal_alert_chk (
   input  wire logic       clk_sys_in,
   input  wire logic       srst_in,
   input  wire logic       auxiliary_reset_n_in,
   input  wire logic       system_reset_n_in,
   input  wire logic       conv_valid_in,
   input  wire logic [7:0] fan_level_out,
   input  wire logic       fan_off_out,
   input  wire logic       alert_n_out,
   input  wire logic       alert_oe_out,
   input  wire logic       overtemp_out_a_n_out,
   input  wire logic       overtemp_out_a_oe_out,
   input  wire logic       overtemp_out_b_n_out,
   input  wire logic       overtemp_out_b_oe_out
);
   // ****************************************
   // Output relations
   // ****************************************
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (srst_in);

   property p_pair;
      overtemp_out_a_n_out == overtemp_out_b_n_out && overtemp_out_a_oe_out == overtemp_out_b_oe_out;
   endproperty
   a_pair: assert property (p_pair) else $error("overtemp outputs differ");

   property p_therm_oe;
      overtemp_out_a_oe_out == !overtemp_out_a_n_out;
   endproperty
   a_therm_oe: assert property (p_therm_oe) else $error("overtemp enable mismatch");

   property p_alert_oe;
      alert_oe_out == !alert_n_out;
   endproperty
   a_alert_oe: assert property (p_alert_oe) else $error("alert enable mismatch");

   property p_forced;
      (!overtemp_out_a_n_out) [*2] |-> fan_level_out == 8'hff && !fan_off_out;
   endproperty
   a_forced: assert property (p_forced) else $error("fan not forced full");

   property p_therm_set;
      $fell(overtemp_out_a_n_out) |-> $past(conv_valid_in) || $past(conv_valid_in, 2)
         || $past(conv_valid_in, 3);
   endproperty
   a_therm_set: assert property (p_therm_set) else $error("overtemp set without conversion");

   property p_therm_clr;
      $rose(overtemp_out_a_n_out) |-> $past(conv_valid_in) || $past(conv_valid_in, 2)
         || $past(conv_valid_in, 3) || !$past(auxiliary_reset_n_in);
   endproperty
   a_therm_clr: assert property (p_therm_clr) else $error("overtemp cleared without cause");

   property p_sys_rst;
      (!system_reset_n_in && overtemp_out_a_n_out) ##1 overtemp_out_a_n_out |-> fan_level_out == 8'h00;
   endproperty
   a_sys_rst: assert property (p_sys_rst) else $error("fan not cleared by system reset");

   property p_aux_rst;
      !auxiliary_reset_n_in |=> fan_level_out == 8'h00 && alert_n_out && overtemp_out_a_n_out;
   endproperty
   a_aux_rst: assert property (p_aux_rst) else $error("aux reset not applied");
endmodule

bind tar_thermal_alert tar_thermal_alert_chk tar_thermal_alert_chk_i (.*);
`default_nettype wire

// File: tb/tar_host.sv
`timescale 1ns/1ps
`default_nettype none
module tar_host
   import tar_pkg::*;
(
   input  wire logic       clk_sys_in,
   input  wire logic [7:0] rdata_in,
   output var  logic       wr_out,
   output var  logic       rd_out,
   output var  logic [7:0] addr_out,
   output var  logic [7:0] wdata_out
);
   // ****************************************
   // Register access, released lines inverted
   // ****************************************
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end

   task automatic wr(input tar_byte_t a, input tar_byte_t d);
      @(negedge clk_sys_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge clk_sys_in);
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask

   task automatic rd(input tar_byte_t a, output tar_byte_t d);
      @(negedge clk_sys_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge clk_sys_in);
      rd_out = 1'b0;
      addr_out = ~a;
      @(negedge clk_sys_in);
      d = rdata_in;
   endtask
endmodule
`default_nettype wire

// File: tb/tar_thermal_alert_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tar_thermal_alert_tb
   import tar_pkg::*;
;
   localparam int RAMP = 4;
   logic      clk_sys_in = 1'b0, srst_in = 1'b1, general_input_in = 1'b0, conv_valid_in = 1'b0;
   logic      auxiliary_reset_n_in = 1'b1, system_reset_n_in = 1'b1;
   logic      reg_wr_in, reg_rd_in, fan_off_out, alert_n_out, alert_oe_out;
   logic      overtemp_out_a_n_out, overtemp_out_a_oe_out, overtemp_out_b_n_out, overtemp_out_b_oe_out;
   tar_byte_t remote_temp_in = 8'h00, internal_temp_in = 8'h19;
   tar_byte_t reg_addr_in, reg_wdata_in, reg_rdata_out, fan_level_out;
   int        errors = 0;
   int        checks = 0;

   tar_thermal_alert #(.RAMP_BASE_CYC(RAMP)) tar_thermal_alert_i (.*);
   tar_host tar_host_i (
      .clk_sys_in (clk_sys_in),
      .rdata_in   (reg_rdata_out),
      .wr_out     (reg_wr_in),
      .rd_out     (reg_rd_in),
      .addr_out   (reg_addr_in),
      .wdata_out  (reg_wdata_in)
   );

   always #20 clk_sys_in = ~clk_sys_in;

   // ****************************************
   // Helpers
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   task automatic chk(input tar_byte_t got, input tar_byte_t exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask

   task automatic wo(input tar_byte_t a, input tar_byte_t d);
      tar_host_i.wr(a, d);
      tick(2);
   endtask

   task automatic rchk(input tar_byte_t a, input tar_byte_t exp);
      tar_byte_t v;
      tar_host_i.rd(a, v);
      chk(v, exp);
   endtask

   task automatic cv(input tar_byte_t t, input int n);
      repeat (n) begin
         @(negedge clk_sys_in);
         remote_temp_in = t;
         conv_valid_in = 1'b1;
         @(negedge clk_sys_in);
         conv_valid_in = 1'b0;
         remote_temp_in = ~t;
      end
      tick(3);
   endtask

   task automatic ramp_to(input tar_byte_t tgt, input int dir, input int per);
      tar_byte_t prev;
      int        gap;
      int        n;
      tick(2);
      prev = fan_level_out;
      gap = 0;
      n = 0;
      repeat (80) begin
         @(negedge clk_sys_in);
         gap++;
         if (fan_level_out !== prev) begin
            chk(fan_level_out, prev + 8'(dir));
            if (n > 0) chk(8'(gap), 8'(per));
            n++;
            gap = 0;
            prev = fan_level_out;
         end
      end
      chk(fan_level_out, tgt);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic s_reset();
      chk(fan_level_out, 8'h00);
      chkb(alert_n_out, 1'b1);
      rchk(8'h40, 8'h21);
      rchk(8'h41, 8'h00);
      rchk(8'h43, 8'h00);
      rchk(8'hc0, 8'h00);
      rchk(8'h14, 8'h64);
      rchk(8'h18, 8'h64);
      rchk(8'h17, 8'h46);
      rchk(8'h77, 8'h00);
   endtask

   task automatic s_ramp();
      wo(8'h42, 8'h80);
      chk(fan_level_out, 8'h80);
      wo(8'hc0, 8'h01);
      ramp_to(8'h80, 1, RAMP);
      wo(8'h42, 8'h83);
      ramp_to(8'h83, 1, RAMP);
      wo(8'h42, 8'h88);
      tick(6);
      wo(8'h42, 8'h80);
      ramp_to(8'h80, -1, RAMP);
      wo(8'hc0, 8'h03);
      wo(8'h42, 8'h84);
      ramp_to(8'h84, 1, 2 * RAMP);
   endtask

   task automatic s_alert();
      wo(8'h40, 8'h23);
      wo(8'h30, 8'h40);
      cv(8'h50, 2);
      chkb(alert_n_out, 1'b1);
      cv(8'h50, 1);
      chkb(alert_n_out, 1'b0);
      chkb(alert_oe_out, 1'b1);
      wo(8'h43, 8'h01);
      chkb(alert_n_out, 1'b1);
      rchk(8'h41, 8'h01);
      wo(8'h43, 8'h00);
      wo(8'h40, 8'h21);
      chkb(alert_n_out, 1'b1);
      rchk(8'h41, 8'h01);
      wo(8'h40, 8'h23);
      wo(8'h41, 8'h01);
      rchk(8'h41, 8'h00);
      cv(8'h50, 3);
      chkb(alert_n_out, 1'b1);
      cv(8'h30, 3);
      cv(8'h50, 3);
      chkb(alert_n_out, 1'b0);
      wo(8'h40, 8'h13);
      rchk(8'h40, 8'h21);
      rchk(8'h41, 8'h00);
      rchk(8'h30, 8'h40);
      wo(8'h40, 8'h23);
      cv(8'h50, 3);
      chkb(alert_n_out, 1'b0);
   endtask

   task automatic s_soft_int();
      wo(8'h41, 8'h01);
      chkb(alert_n_out, 1'b1);
      wo(8'h41, 8'h04);
      rchk(8'h41, 8'h04);
      chkb(alert_n_out, 1'b0);
      wo(8'h41, 8'h04);
      rchk(8'h41, 8'h00);
   endtask

   task automatic s_input();
      general_input_in = 1'b1;
      tick(2);
      rchk(8'h41, 8'h10);
      chkb(alert_n_out, 1'b0);
      wo(8'h41, 8'h10);
      rchk(8'h41, 8'h10);
      wo(8'h40, 8'h63);
      rchk(8'h41, 8'h00);
      general_input_in = 1'b0;
      tick(2);
      rchk(8'h41, 8'h10);
      wo(8'h40, 8'h23);
      rchk(8'h41, 8'h00);
   endtask

   task automatic s_therm();
      wo(8'h43, 8'h01);
      cv(8'h65, 2);
      cv(8'h50, 1);
      cv(8'h65, 2);
      chkb(overtemp_out_a_n_out, 1'b1);
      chkb(alert_n_out, 1'b1);
      cv(8'h65, 1);
      chkb(overtemp_out_a_n_out, 1'b0);
      chkb(overtemp_out_b_n_out, 1'b0);
      chk(fan_level_out, 8'hff);
      chkb(fan_off_out, 1'b0);
      chkb(alert_n_out, 1'b0);
      wo(8'hc0, 8'h00);
      wo(8'h42, 8'h10);
      cv(8'h60, 3);
      chk(fan_level_out, 8'hff);
      cv(8'h5f, 3);
      chkb(overtemp_out_a_n_out, 1'b1);
      chk(fan_level_out, 8'h10);
   endtask

   task automatic s_lock();
      wo(8'h14, 8'h50);
      rchk(8'h14, 8'h50);
      wo(8'h40, 8'h2b);
      wo(8'h14, 8'h60);
      rchk(8'h14, 8'h50);
      wo(8'h40, 8'h23);
      rchk(8'h40, 8'h2b);
      system_reset_n_in = 1'b0;
      tick(2);
      system_reset_n_in = 1'b1;
      tick(1);
      chk(fan_level_out, 8'h00);
      rchk(8'h40, 8'h23);
      rchk(8'h42, 8'h00);
   endtask

   task automatic s_aux();
      wo(8'h42, 8'h40);
      auxiliary_reset_n_in = 1'b0;
      tick(2);
      auxiliary_reset_n_in = 1'b1;
      tick(1);
      chk(fan_level_out, 8'h00);
      rchk(8'h40, 8'h21);
      rchk(8'h14, 8'h64);
   endtask

   task automatic conclude();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      tick(3);
      srst_in = 1'b0;
      tick(1);
      s_reset();
      s_ramp();
      s_alert();
      s_soft_int();
      s_input();
      s_therm();
      s_lock();
      s_aux();
      conclude();
   end

   initial begin
      #(40 * 20000);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
endmodule
`default_nettype wire
